// >>> serial_port_pkg.sv
// Shared constants and state types for the dual serial register port.
// Assumes a single 40 MHz system clock at both ends of the link.
package serial_port_pkg;

   // ****************************************
   // Register space
   // ****************************************
   localparam int REG_AW = 10;
   localparam int REG_DW = 16;
   localparam int REG_WORDS = 2 ** REG_AW;
   localparam int BYTE_W = 8;

   // ****************************************
   // SPI frame layout
   // ****************************************
   localparam int SPI_FRAME = 32;
   localparam int SPI_HDR = 16;
   localparam int SPI_ADDR_BITS = 15;
   localparam int SPI_RW_POS = 0;
   localparam int SPI_ADDR_LSB = 1;
   localparam logic RW_WRITE = 1'b1;

   // ****************************************
   // I2C addressing
   // ****************************************
   localparam int SLV_W = 7;
   localparam logic [6:0] I2C_BASE_GND = 7'h2c;
   localparam logic [6:0] I2C_BASE_IO = 7'h3c;
   localparam int PAGE_W = 2;
   localparam int PAGE_LSB = 1;
   localparam int I2C_RW_POS = 0;
   localparam logic I2C_READ = 1'b1;
   localparam int ACK_SLOT = 8;
   localparam logic STRAP_I2C = 1'b1;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int LINK_PERIOD_NS = 200;
   localparam int HALF_CYCLES = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

   typedef enum logic [2:0] {
      I_IDLE = 3'b000,
      I_ADDR = 3'b001,
      I_REG = 3'b010,
      I_WHI = 3'b011,
      I_WLO = 3'b100,
      I_RHI = 3'b101,
      I_RLO = 3'b110
   } i2c_state_t;

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_SPI = 3'b001,
      H_START = 3'b010,
      H_BYTE = 3'b011,
      H_STOP = 3'b100
   } host_state_t;

endpackage

// >>> serial_link.sv
// Four shared pins between the host and the device.
// Assumes a pull-up on each data pin: a released pin reads high.
`timescale 1ns/1ps
interface serial_link;
   logic select_or_address_pin;
   logic serial_clock_pin;
   logic host_dat_o;
   logic host_dat_oe_n;
   logic dev_dat_o;
   logic dev_dat_oe_n;
   logic host_aux_o;
   logic host_aux_oe_n;
   logic dev_aux_o;
   logic dev_aux_oe_n;
   logic shared_data_in_pin;
   logic data_out_or_dimming_pin;

   // Wired level: an enabled driver pulls to its value, else pulled high
   assign shared_data_in_pin = (host_dat_oe_n | host_dat_o)
                             & (dev_dat_oe_n | dev_dat_o);
   assign data_out_or_dimming_pin = (host_aux_oe_n | host_aux_o)
                                  & (dev_aux_oe_n | dev_aux_o);

   modport host_end (
      output select_or_address_pin, serial_clock_pin,
      output host_dat_o, host_dat_oe_n, host_aux_o, host_aux_oe_n,
      input shared_data_in_pin, data_out_or_dimming_pin
   );
   modport dev_end (
      input select_or_address_pin, serial_clock_pin,
      input shared_data_in_pin, data_out_or_dimming_pin,
      output dev_dat_o, dev_dat_oe_n, dev_aux_o, dev_aux_oe_n
   );
endinterface

// >>> serial_port_device.sv
// Device end: strap-selected SPI or I2C slave over a 1K x 16 register file.
// Assumes all pin inputs are asynchronous to clk and standby comes from
// the local state machine on clk.
`timescale 1ns/1ps
module serial_port_device (
   input logic clk,
   input logic resetn,
   serial_link.dev_end link,
   input logic interface_select_strap,
   input logic core_por_ok,
   input logic io_por_ok,
   input logic standby,
   output logic ready,
   output logic i2c_mode,
   output logic pwm_level,
   output logic wr_strobe,
   output logic [serial_port_pkg::REG_AW-1:0] wr_addr,
   output logic [serial_port_pkg::REG_DW-1:0] wr_data
);
   import serial_port_pkg::*;

   localparam int CW = $clog2(SPI_FRAME);
   localparam int NSYNC = 7;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [NSYNC-1:0] meta;
   logic [NSYNC-1:0] syn;
   logic scl_d;
   logic dat_d;
   wire [NSYNC-1:0] raw = {link.select_or_address_pin,
      link.serial_clock_pin, link.shared_data_in_pin,
      link.data_out_or_dimming_pin, interface_select_strap,
      core_por_ok, io_por_ok};
   wire sel_s = syn[6];
   wire scl_s = syn[5];
   wire dat_s = syn[4];
   wire aux_s = syn[3];
   wire strap_s = syn[2];
   wire por_ok = syn[1] & syn[0];
   wire address_select = sel_s;
   wire rise = scl_s & ~scl_d;
   wire fall = ~scl_s & scl_d;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         meta <= '0;
         syn <= '0;
         scl_d <= 1'b0;
         dat_d <= 1'b0;
      end else begin
         meta <= raw;
         syn <= meta;
         scl_d <= scl_s;
         dat_d <= dat_s;
      end
   end

   // ****************************************
   // Start-up and interface choice
   // ****************************************
   always_ff @(posedge clk) begin
      if (!resetn || !por_ok) begin
         ready <= 1'b0;
         i2c_mode <= 1'b0;
      end else if (!ready) begin
         ready <= 1'b1;
         i2c_mode <= (strap_s == STRAP_I2C);
      end
   end

   wire spi_on = ready & ~i2c_mode;
   wire i2c_on = ready & i2c_mode;

   // ****************************************
   // Register store
   // ****************************************
   logic [REG_DW-1:0] regs [0:REG_WORDS-1];

   // ****************************************
   // SPI slave
   // ****************************************
   logic [CW-1:0] bit_cnt;
   logic [REG_DW-1:0] shin;
   logic [REG_AW-1:0] spi_addr;
   logic spi_wr;
   logic [REG_DW-1:0] tx;
   logic sdo;
   logic sdo_oe_n;

   wire spi_active = spi_on & ~sel_s;
   wire [REG_DW-1:0] shin_next = {shin[REG_DW-2:0], dat_s};
   wire hdr_done = bit_cnt == CW'(SPI_HDR - 1);
   wire word_done = bit_cnt == CW'(SPI_FRAME - 1);
   // Only the low address bits are decoded
   wire [REG_AW-1:0] hdr_addr = shin_next[SPI_ADDR_LSB +: REG_AW];
   wire hdr_write = shin_next[SPI_RW_POS] == RW_WRITE;
   wire [REG_AW-1:0] spi_addr_inc = spi_addr + 1'b1;
   wire spi_we = spi_active & rise & word_done & spi_wr & standby;
   wire next_sdo_oe_n = ~spi_active | spi_wr
                      | (rise & hdr_done & hdr_write);

   always_ff @(posedge clk) begin
      if (!resetn || !spi_active) begin
         bit_cnt <= '0;
         shin <= '0;
         spi_addr <= '0;
         spi_wr <= 1'b0;
         tx <= '0;
      end else if (rise) begin
         shin <= shin_next;
         // Held select continues with the next word
         bit_cnt <= word_done ? CW'(SPI_HDR) : bit_cnt + 1'b1;
         if (hdr_done) begin
            spi_addr <= hdr_addr;
            spi_wr <= hdr_write;
            tx <= regs[hdr_addr];
         end
         if (word_done) begin
            spi_addr <= spi_addr_inc;
            tx <= regs[spi_addr_inc];
         end
      end else if (fall && bit_cnt >= CW'(SPI_HDR)) begin
         tx <= {tx[REG_DW-2:0], 1'b0};
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         sdo <= 1'b0;
         sdo_oe_n <= 1'b1;
      end else begin
         sdo_oe_n <= next_sdo_oe_n;
         if (!spi_active) begin
            sdo <= 1'b0;
         end else if (fall && bit_cnt >= CW'(SPI_HDR)) begin
            sdo <= tx[REG_DW-1];
         end
      end
   end

   // ****************************************
   // I2C slave
   // ****************************************
   i2c_state_t ist;
   logic [3:0] icnt;
   logic ack_ph;
   logic [BYTE_W-1:0] rx;
   logic [PAGE_W-1:0] page;
   logic [BYTE_W-1:0] ptr;
   logic [BYTE_W-1:0] hi;
   logic [BYTE_W-1:0] itx;
   logic sda_oe_n;

   wire i2c_busy = ist != I_IDLE;
   wire start_c = scl_s & scl_d & dat_d & ~dat_s;
   wire stop_c = scl_s & scl_d & ~dat_d & dat_s;
   wire byte_end = i2c_busy & fall & ~ack_ph & (icnt == 4'(ACK_SLOT));
   wire ack_end = fall & ack_ph;
   wire [SLV_W-1:0] base = address_select ? I2C_BASE_IO
                                          : I2C_BASE_GND;
   wire addr_hit = rx[BYTE_W-1:PAGE_LSB+PAGE_W]
                == base[SLV_W-1:PAGE_W];
   wire take = (ist == I_ADDR & addr_hit) | ist == I_REG
             | ist == I_WHI | ist == I_WLO;
   wire reading = ist == I_RHI | ist == I_RLO;
   wire [REG_AW-1:0] i2c_idx = {page, ptr};
   wire [REG_DW-1:0] rd_word = regs[i2c_idx];
   wire [BYTE_W-1:0] rd_byte = (ist == I_RHI) ? rd_word[REG_DW-1:BYTE_W]
                                            : rd_word[BYTE_W-1:0];
   wire i2c_we = i2c_on & byte_end & ist == I_WLO & standby;

   always_ff @(posedge clk) begin
      if (!resetn || !i2c_on) begin
         ist <= I_IDLE;
         icnt <= '0;
         ack_ph <= 1'b0;
         rx <= '0;
         page <= '0;
         ptr <= '0;
         hi <= '0;
         itx <= '0;
         sda_oe_n <= 1'b1;
      end else if (start_c) begin
         ist <= I_ADDR; // Also a repeated start
         icnt <= '0;
         ack_ph <= 1'b0;
         sda_oe_n <= 1'b1;
      end else if (stop_c) begin
         ist <= I_IDLE;
         ack_ph <= 1'b0;
         sda_oe_n <= 1'b1;
      end else if (rise && ack_ph) begin
         // Master not-acknowledge ends a read
         if (reading && dat_s) begin
            ist <= I_IDLE;
         end
      end else if (rise && i2c_busy && icnt != 4'(ACK_SLOT)) begin
         rx <= {rx[BYTE_W-2:0], dat_s};
         icnt <= icnt + 1'b1;
      end else if (byte_end) begin
         ack_ph <= 1'b1;
         sda_oe_n <= ~take;
         case (ist)
            I_ADDR: begin
               if (!addr_hit) begin
                  ist <= I_IDLE;
               end else begin
                  page <= rx[PAGE_LSB +: PAGE_W];
                  ist <= (rx[I2C_RW_POS] == I2C_READ) ? I_RHI : I_REG;
               end
            end
            I_REG: begin
               ptr <= rx;
               ist <= I_WHI;
            end
            I_WHI: begin
               hi <= rx;
               ist <= I_WLO;
            end
            I_WLO: begin
               ptr <= ptr + 1'b1;
               ist <= I_WHI;
            end
            I_RHI: ist <= I_RLO;
            I_RLO: begin
               ptr <= ptr + 1'b1;
               ist <= I_RHI;
            end
            default: ist <= I_IDLE;
         endcase
      end else if (ack_end) begin
         ack_ph <= 1'b0;
         icnt <= '0;
         sda_oe_n <= ~reading | rd_byte[BYTE_W-1];
         itx <= {rd_byte[BYTE_W-2:0], 1'b0};
      end else if (fall && reading && icnt != '0) begin
         sda_oe_n <= itx[BYTE_W-1];
         itx <= {itx[BYTE_W-2:0], 1'b0};
      end
   end

   // ****************************************
   // Register writes and pin drive
   // ****************************************
   wire mem_we = spi_we | i2c_we;
   wire [REG_AW-1:0] mem_wa = i2c_on ? i2c_idx : spi_addr;
   wire [REG_DW-1:0] mem_wd = i2c_on ? {hi, rx} : shin_next;

   always_ff @(posedge clk) begin
      if (mem_we) begin
         regs[mem_wa] <= mem_wd;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wr_strobe <= 1'b0;
         wr_addr <= '0;
         wr_data <= '0;
         pwm_level <= 1'b0;
      end else begin
         wr_strobe <= mem_we;
         if (mem_we) begin
            wr_addr <= mem_wa;
            wr_data <= mem_wd;
         end
         pwm_level <= i2c_on & aux_s;
      end
   end

   // Data pin is open-drain in I2C and an input in SPI
   assign link.dev_dat_o = 1'b0;
   assign link.dev_dat_oe_n = sda_oe_n;
   assign link.dev_aux_o = sdo;
   assign link.dev_aux_oe_n = sdo_oe_n;

endmodule

// >>> serial_port_host.sv
// Host end: one register write or read per request, over SPI or I2C.
// Assumes req is on clk and the pins return through two flip-flops.
`timescale 1ns/1ps
module serial_port_host #(
   parameter int HALF = serial_port_pkg::HALF_CYCLES
) (
   input logic clk,
   input logic resetn,
   serial_link.host_end link,
   input logic i2c_mode,
   input logic address_select,
   input logic pwm_in,
   input logic req,
   input logic req_write,
   input logic [serial_port_pkg::REG_AW-1:0] req_addr,
   input logic [serial_port_pkg::REG_DW-1:0] req_wdata,
   output logic busy,
   output logic done,
   output logic nack,
   output logic [serial_port_pkg::REG_DW-1:0] rdata
);
   import serial_port_pkg::*;

   localparam int HW = $clog2(HALF + 1);
   localparam logic [2:0] B_SLAVE = 3'h0;
   localparam logic [2:0] B_REG = 3'h1;
   localparam logic [2:0] B_THIRD = 3'h2;
   localparam logic [2:0] B_FOURTH = 3'h3;

   // ****************************************
   // State
   // ****************************************
   logic [1:0] meta;
   logic [1:0] syn;
   logic [HW-1:0] div;
   host_state_t st;
   logic [1:0] ph;
   logic [5:0] bcnt;
   logic [2:0] bi;
   logic op_wr;
   logic [REG_AW-1:0] addr;
   logic [REG_DW-1:0] wdata;
   logic [SPI_FRAME-1:0] sh;
   logic [BYTE_W:0] ob;
   logic [REG_DW-1:0] rx;
   logic sel;
   logic sclk;
   logic dat_o;
   logic dat_oe_n;
   logic aux_o;
   logic aux_oe_n;

   wire dat_s = syn[1];
   wire aux_s = syn[0];
   wire tick = busy & (div == HW'(HALF - 1));
   wire host_drove = op_wr | (bi < B_FOURTH);
   wire last_byte = op_wr ? (bi == B_FOURTH) : (bi == B_FOURTH + 3'h1);
   wire [REG_DW-1:0] rx_next = {rx[REG_DW-2:0], i2c_mode ? dat_s : aux_s};
   wire [SPI_FRAME-1:0] spi_word = {(SPI_ADDR_BITS - REG_AW)'(0),
      req_addr, req_write ? RW_WRITE : ~RW_WRITE, req_wdata};

   // Nine bit times per byte; the last is the acknowledge level
   function automatic logic [BYTE_W:0] frame(input logic [2:0] n);
      logic [SLV_W-1:0] slave;
      slave = {address_select ? I2C_BASE_IO[SLV_W-1:PAGE_W]
                              : I2C_BASE_GND[SLV_W-1:PAGE_W],
               addr[REG_AW-1 -: PAGE_W]};
      case (n)
         B_SLAVE: frame = {slave, ~I2C_READ, 1'b1};
         B_REG: frame = {addr[BYTE_W-1:0], 1'b1};
         B_THIRD: frame = op_wr ? {wdata[REG_DW-1:BYTE_W], 1'b1}
                                : {slave, I2C_READ, 1'b1};
         B_FOURTH: frame = op_wr ? {wdata[BYTE_W-1:0], 1'b1}
                                 : {{BYTE_W{1'b1}}, 1'b0};
         default: frame = {{BYTE_W{1'b1}}, 1'b1};
      endcase
   endfunction

   always_ff @(posedge clk) begin
      if (!resetn) begin
         meta <= '0;
         syn <= '0;
         div <= '0;
         aux_o <= 1'b0;
         aux_oe_n <= 1'b1;
      end else begin
         meta <= {link.shared_data_in_pin, link.data_out_or_dimming_pin};
         syn <= meta;
         div <= (!busy || tick) ? '0 : div + 1'b1;
         aux_o <= pwm_in;
         aux_oe_n <= ~i2c_mode;
      end
   end

   // ****************************************
   // Transfer sequencer
   // ****************************************
   always_ff @(posedge clk) begin
      if (!resetn) begin
         st <= H_IDLE;
         ph <= '0;
         bcnt <= '0;
         bi <= '0;
         op_wr <= 1'b0;
         addr <= '0;
         wdata <= '0;
         sh <= '0;
         ob <= '0;
         rx <= '0;
         sel <= 1'b1;
         sclk <= 1'b0;
         dat_o <= 1'b0;
         dat_oe_n <= 1'b1;
         busy <= 1'b0;
         done <= 1'b0;
         nack <= 1'b0;
         rdata <= '0;
      end else begin
         done <= 1'b0;
         case (st)
            H_IDLE: begin
               sel <= i2c_mode ? address_select : 1'b1;
               sclk <= i2c_mode;
               dat_o <= 1'b0;
               dat_oe_n <= i2c_mode;
               ph <= '0;
               bcnt <= '0;
               bi <= '0;
               if (req) begin
                  busy <= 1'b1;
                  nack <= 1'b0;
                  op_wr <= req_write;
                  addr <= req_addr;
                  wdata <= req_wdata;
                  st <= i2c_mode ? H_START : H_SPI;
                  if (!i2c_mode) begin
                     sel <= 1'b0;
                     sh <= spi_word;
                     dat_o <= spi_word[SPI_FRAME-1];
                  end
               end
            end
            H_SPI: if (tick) begin
               if (ph == 2'd0) begin
                  sclk <= 1'b1;
                  ph <= 2'd1;
               end else begin
                  // Sample late in the high half, change on the fall
                  sclk <= 1'b0;
                  ph <= 2'd0;
                  rx <= rx_next;
                  sh <= {sh[SPI_FRAME-2:0], 1'b0};
                  dat_o <= sh[SPI_FRAME-2];
                  bcnt <= bcnt + 1'b1;
                  if (bcnt == 6'(SPI_FRAME - 1)) begin
                     sel <= 1'b1;
                     st <= H_IDLE;
                     busy <= 1'b0;
                     done <= 1'b1;
                     rdata <= rx_next;
                  end
               end
            end
            H_START: if (tick) begin
               ph <= ph + 1'b1;
               case (ph)
                  2'd0: dat_oe_n <= 1'b1;
                  2'd1: sclk <= 1'b1;
                  2'd2: dat_oe_n <= 1'b0;
                  default: begin
                     sclk <= 1'b0;
                     st <= H_BYTE;
                     bcnt <= '0;
                     ob <= frame(bi);
                  end
               endcase
            end
            H_BYTE: if (tick) begin
               if (ph == 2'd0) begin
                  dat_oe_n <= ob[BYTE_W];
                  ob <= {ob[BYTE_W-1:0], 1'b0};
                  ph <= 2'd1;
               end else if (ph == 2'd1) begin
                  sclk <= 1'b1;
                  ph <= 2'd2;
               end else begin
                  sclk <= 1'b0;
                  ph <= 2'd0;
                  if (bcnt != 6'(ACK_SLOT)) begin
                     bcnt <= bcnt + 1'b1;
                     if (!host_drove) begin
                        rx <= rx_next;
                     end
                  end else if (host_drove && dat_s) begin
                     nack <= 1'b1;
                     st <= H_STOP;
                  end else if (last_byte) begin
                     st <= H_STOP;
                  end else begin
                     bi <= bi + 1'b1;
                     bcnt <= '0;
                     ob <= frame(bi + 1'b1);
                     if (!op_wr && bi == B_REG) begin
                        st <= H_START;
                     end
                  end
               end
            end
            H_STOP: if (tick) begin
               ph <= ph + 1'b1;
               case (ph)
                  2'd0: dat_oe_n <= 1'b0;
                  2'd1: sclk <= 1'b1;
                  default: begin
                     dat_oe_n <= 1'b1;
                     st <= H_IDLE;
                     busy <= 1'b0;
                     done <= 1'b1;
                     rdata <= rx;
                  end
               endcase
            end
            default: st <= H_IDLE;
         endcase
      end
   end

   assign link.select_or_address_pin = sel;
   assign link.serial_clock_pin = sclk;
   assign link.host_dat_o = dat_o;
   assign link.host_dat_oe_n = dat_oe_n;
   assign link.host_aux_o = aux_o;
   assign link.host_aux_oe_n = aux_oe_n;

endmodule

// >>> dual_serial_register_port_chk.sv
// Checker on the link signals between the host and device ends.
// Assumes the link is idle with select high outside SPI frames.
`timescale 1ns/1ps
module dual_serial_register_port_chk (
   input wire logic clk,
   input wire logic resetn,
   input wire logic select_or_address_pin,
   input wire logic serial_clock_pin,
   input wire logic shared_data_in_pin,
   input wire logic dev_aux_o,
   input wire logic dev_aux_oe_n,
   input wire logic host_aux_oe_n
);
   // ****************************************
   // Frame tracking
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   logic sclk_q;
   logic dir_bit;
   logic [5:0] rises;
   // Host drives the dimming pin only in I2C mode: no SPI frame then
   wire sel = select_or_address_pin | ~host_aux_oe_n;
   wire rise = serial_clock_pin & ~sclk_q;
   always_ff @(posedge clk) begin
      sclk_q <= serial_clock_pin;
      if (!resetn || sel) begin
         rises <= 6'h00;
      end else if (rise) begin
         rises <= rises + 6'h01;
      end
   end
   // Direction bit is the sixteenth bit of the frame
   always_ff @(posedge clk) begin
      if (!resetn) begin
         dir_bit <= 1'b0;
      end else if (rise && rises == 6'h0f) begin
         dir_bit <= shared_data_in_pin;
      end
   end
   chk_sdo_idle_float: assert property (sel [*4] |-> dev_aux_oe_n)
      else $error("data out driven while unselected");
   chk_sdo_low_sel: assert property ($fell(sel) |->
      ##[1:6] (!dev_aux_oe_n && !dev_aux_o))
      else $error("data out not low after select");
   chk_sclk_low_start: assert property ($fell(sel) |-> !serial_clock_pin)
      else $error("clock high at frame start");
   chk_frame_bits: assert property ($rose(sel) |-> rises == 6'h20)
      else $error("frame not 32 bits");
   chk_write_float: assert property (!sel && rises >= 6'h11 && dir_bit
      |-> dev_aux_oe_n)
      else $error("data out driven during write");
   chk_read_drive: assert property (!sel && rises >= 6'h12
      && rises <= 6'h1f && !dir_bit |-> !dev_aux_oe_n)
      else $error("data out released during read");
   chk_pad_zero: assert property (rise && !sel && rises < 6'h05
      |-> !shared_data_in_pin)
      else $error("unused address bit set");
   chk_select_end: assert property ($rose(sel) |-> !serial_clock_pin)
      else $error("select rose with clock high");
   chk_engine_reset: assert property ($rose(sel) |-> ##[1:6] dev_aux_oe_n)
      else $error("data out held after select rose");
endmodule

// >>> test_dual_serial_register_port.sv
// Bench joining host and device ends over one serial link.
// Assumes both ends run on clk; strap and supplies are driven here.
`timescale 1ns/1ps
module test_dual_serial_register_port;
   import serial_port_pkg::*;
   // ****************************************
   // Ends and checker
   // ****************************************
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic strap = 1'b0;
   logic io_ok = 1'b0;
   logic core_ok = 1'b1;
   logic adr_sel = 1'b1;
   logic standby = 1'b1;
   logic mode = 1'b0;
   logic pwm_in = 1'b0;
   logic req = 1'b0;
   logic req_write = 1'b0;
   logic [REG_AW-1:0] req_addr = '0;
   logic [REG_DW-1:0] req_wdata = '0;
   logic ready, dev_i2c, pwm_level, wr_strobe, busy, done, nack;
   logic [REG_AW-1:0] wr_addr;
   logic [REG_DW-1:0] wr_data, rdata;
   int error_cnt = 0;
   int compares = 0;
   int strobes = 0;
   int stored = 0;
   serial_link lnk ();
   serial_port_host i_serial_port_host (.clk(clk), .resetn(resetn),
      .link(lnk), .i2c_mode(mode), .address_select(adr_sel),
      .pwm_in(pwm_in),
      .req(req), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .busy(busy), .done(done), .nack(nack),
      .rdata(rdata));
   serial_port_device i_serial_port_device (.clk(clk), .resetn(resetn),
      .link(lnk), .interface_select_strap(strap), .core_por_ok(core_ok),
      .io_por_ok(io_ok), .standby(standby), .ready(ready),
      .i2c_mode(dev_i2c), .pwm_level(pwm_level), .wr_strobe(wr_strobe),
      .wr_addr(wr_addr), .wr_data(wr_data));
   dual_serial_register_port_chk i_chk (.clk(clk), .resetn(resetn),
      .select_or_address_pin(lnk.select_or_address_pin),
      .serial_clock_pin(lnk.serial_clock_pin),
      .shared_data_in_pin(lnk.shared_data_in_pin),
      .dev_aux_o(lnk.dev_aux_o), .dev_aux_oe_n(lnk.dev_aux_oe_n),
      .host_aux_oe_n(lnk.host_aux_oe_n));
   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (wr_strobe === 1'b1) strobes++;
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic check(input string name, input logic [15:0] exp,
                        input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic results();
      if (error_cnt == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic await(ref logic sig, input int lim);
      int n;
      n = 0;
      while (sig !== 1'b1) begin
         if (n == lim) begin
            error_cnt++;
            results();
         end
         @(posedge clk);
         n++;
      end
   endtask
   task automatic xfer(input logic w, input logic [9:0] a,
                       input logic [15:0] d);
      @(posedge clk);
      req <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      @(posedge clk);
      req <= 1'b0;
      await(done, 3000);
      check("busy", 16'h0000, {15'h0000, busy});
   endtask
   task automatic wr(input logic [9:0] a, input logic [15:0] d,
                     input int keep);
      xfer(1'b1, a, d);
      repeat (10) @(posedge clk);
      stored += keep;
      check("strobes", 16'(stored), 16'(strobes));
      if (keep == 1) begin
         check("wr_addr", {6'h00, a}, {6'h00, wr_addr});
         check("wr_data", d, wr_data);
      end
   endtask
   task automatic rd(input logic [9:0] a, input logic [15:0] e);
      xfer(1'b0, a, 16'h0000);
      check("rdata", e, rdata);
      check("nack", 16'h0000, {15'h0000, nack});
   endtask
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      repeat (10) @(posedge clk);
      check("ready", 16'h0000, {15'h0000, ready});
      io_ok <= 1'b1;
      await(ready, 20);
      check("mode", 16'h0000, {15'h0000, dev_i2c});
      wr(10'h3ff, 16'ha5c3, 1);
      wr(10'h001, 16'h8001, 1);
      rd(10'h3ff, 16'ha5c3);
      rd(10'h001, 16'h8001);
      standby <= 1'b0;
      wr(10'h001, 16'h1234, 0);
      rd(10'h001, 16'h8001);
      standby <= 1'b1;
      strap <= 1'b1;
      repeat (8) @(posedge clk);
      check("mode", 16'h0000, {15'h0000, dev_i2c});
      core_ok <= 1'b0;
      repeat (8) @(posedge clk);
      check("ready", 16'h0000, {15'h0000, ready});
      core_ok <= 1'b1;
      await(ready, 20);
      check("mode", 16'h0001, {15'h0000, dev_i2c});
      mode <= 1'b1;
      pwm_in <= 1'b1;
      repeat (8) @(posedge clk);
      check("pwm", 16'h0001, {15'h0000, pwm_level});
      rd(10'h3ff, 16'ha5c3);
      for (int p = 0; p < 4; p++) begin
         wr({p[1:0], 8'h5a}, {6'h2b, p[1:0], 8'hc4}, 1);
         rd({p[1:0], 8'h5a}, {6'h2b, p[1:0], 8'hc4});
      end
      adr_sel <= 1'b0;
      wr(10'h0c3, 16'h7e81, 1);
      rd(10'h0c3, 16'h7e81);
      pwm_in <= 1'b0;
      repeat (8) @(posedge clk);
      check("pwm", 16'h0000, {15'h0000, pwm_level});
      results();
   end
endmodule
